/* verilog/fsa_pkg.sv */
/*
 Constants for the frame-sync alignment block: register map,
 field positions, reset values, phase codes and recalibration states.
 Assumes it is compiled before every file that refers to it.
*/
package fsa_pkg;
  // Printed offsets are register indices; byte address is four times that
  localparam logic [11:0] IDX_CFG_A   = 12'h07A;
  localparam logic [11:0] IDX_CFG_B   = 12'h07B;
  localparam logic [11:0] IDX_CFG_C   = 12'h07C;
  localparam logic [11:0] ADDR_CFG_A  = 12'(IDX_CFG_A * 4);
  localparam logic [11:0] ADDR_CFG_B  = 12'(IDX_CFG_B * 4);
  localparam logic [11:0] ADDR_CFG_C  = 12'(IDX_CFG_C * 4);
  localparam logic [11:0] ADDR_STATUS = 12'h200;
  localparam logic [11:0] ADDR_MASK   = 12'h204;
  localparam logic [11:0] ADDR_STATE  = 12'h208;

  localparam logic [7:0] RST_CFG_A = 8'h00;
  localparam logic [7:0] RST_CFG_B = 8'h00;
  localparam logic [7:0] RST_CFG_C = 8'h2B;

  // Config A fields
  localparam int CA_DPLL_SEL = 7;
  localparam int CA_PAIR_MSB = 6;
  localparam int CA_PAIR_MID = 5;
  localparam int CA_PAIR_LSB = 4;
  localparam int CA_FP_INV   = 3;
  localparam int CA_FP_NAR   = 2;
  localparam int CA_MF_INV   = 1;
  localparam int CA_MF_NAR   = 0;
  // Config B fields
  localparam int CB_DECOUPLE = 7;
  localparam int CB_HIGHRATE = 6;
  localparam int CB_PH3      = 4;
  localparam int CB_PH2      = 2;
  localparam int CB_PH1      = 0;
  // Config C fields
  localparam int CC_OFFSET_RECALIBRATE    = 7;
  localparam int CC_LIM      = 4;
  localparam int CC_SRC      = 0;

  // Status and mask bits
  localparam int ST_MISALIGN = 0;
  localparam int ST_OFFSET_RECALIBRATE    = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sample phase codes
  localparam logic [1:0] PH_COINC      = 2'h0;
  localparam logic [1:0] PH_HALF_EARLY = 2'h1;
  localparam logic [1:0] PH_ONE_LATE   = 2'h2;
  localparam logic [1:0] PH_HALF_LATE  = 2'h3;

  localparam logic [3:0] CLK_NONE = 4'h0;
  localparam logic [3:0] MON_MAX  = 4'hF;

  typedef enum logic [2:0] {
    RC_IDLE   = 3'b000,
    RC_HOLD   = 3'b001,
    RC_ZERO   = 3'b010,
    RC_DIVRST = 3'b011,
    RC_BACK   = 3'b100,
    RC_EXIT   = 3'b101
  } fsa_offset_recalibrate_e;
endpackage : fsa_pkg

/* verilog/fsa_frame_sync.sv */
/*
 Frame-sync alignment block: AXI4-Lite register slave, frame and
 multiframe output shaping, sync pin pairing, sampling, misalignment
 monitor, offset recalibration sequencer and interrupt.
 Assumes DPLL squares, half-interval ticks, output_clock_3 tick and
 ramp-done come from logic on ref_clk; sync pins are asynchronous.
*/
`timescale 1ns/1ps
module fsa_frame_sync (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        mainFrame,
  input  wire logic        auxFrame,
  input  wire logic        mainMultiframe,
  input  wire logic        auxMultiframe,
  input  wire logic        auxLocksToMain,
  input  wire logic        oc3Tick,
  input  wire logic [2:0]  syncPin,
  input  wire logic        lowRateHalfTick,
  input  wire logic        refRateHalfTick,
  input  wire logic        rampDone,
  output logic             framePulseOut,
  output logic             multiframePulseOut,
  output logic [3:0]       pairClk1,
  output logic [3:0]       pairClk2,
  output logic [3:0]       pairClk3,
  output logic             threePinMode,
  output logic             syncIgnored,
  output logic             resyncAll,
  output logic             resyncFrameOnly,
  output logic             miniHoldover,
  output logic             rampToZero,
  output logic             rampToOffset,
  output logic             dividerReset,
  output logic             misalignAlarm,
  output logic             irq
);
  logic [7:0]  cfgA, cfgB, cfgC;
  logic [1:0]  status, mask;
  logic        wrEn, rdEn, wrOk;
  logic        selAux, sq8, sq2, prev8, prev2, pul8, pul2;
  logic        rise8, rise2;
  logic [2:0]  syncMeta, syncSafe;
  logic [3:0]  hist [3];
  logic [2:0]  sampled, sampledPrev, syncFall;
  logic        halfTick, halfPhase, tick, syncEvt, undefSrc, threePin;
  logic [3:0]  sinceMf, pendCnt, limit;
  logic        pending;
  logic [3:0]  next_pair1, next_pair2, next_pair3;
  logic [31:0] next_rdata;
  logic        next_rdErr;
  fsa_pkg::fsa_offset_recalibrate_e rcState, next_rcState;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // AXI write: wait for both channels, then a one-cycle ready pulse
  assign wrEn = awvalid && awready && wvalid && wready;
  assign wrOk = awaddr == fsa_pkg::ADDR_CFG_A || awaddr == fsa_pkg::ADDR_CFG_B
             || awaddr == fsa_pkg::ADDR_CFG_C || awaddr == fsa_pkg::ADDR_MASK
             || awaddr == fsa_pkg::ADDR_STATUS || awaddr == fsa_pkg::ADDR_STATE;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= fsa_pkg::RESP_OKAY;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
      if (wrEn) begin
        bvalid <= 1'b1;
        bresp  <= wrOk ? fsa_pkg::RESP_OKAY : fsa_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read mux; the recalibrate bit reads back live
  always_comb begin
    next_rdata = 32'h0;
    next_rdErr = 1'b0;
    unique case (araddr)
      fsa_pkg::ADDR_CFG_A:  next_rdata = {24'h0, cfgA};
      fsa_pkg::ADDR_CFG_B:  next_rdata = {24'h0, cfgB};
      fsa_pkg::ADDR_CFG_C:  next_rdata = {24'h0, cfgC};
      fsa_pkg::ADDR_STATUS: next_rdata = {30'h0, status};
      fsa_pkg::ADDR_MASK:   next_rdata = {30'h0, mask};
      fsa_pkg::ADDR_STATE:  next_rdata = {29'h0, pending, threePin, misalignAlarm};
      default:              next_rdErr = 1'b1;
    endcase
  end

  assign rdEn = arvalid && arready;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= fsa_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rdEn) begin
        rvalid <= 1'b1;
        rdata  <= next_rdata;
        rresp  <= next_rdErr ? fsa_pkg::RESP_SLVERR : fsa_pkg::RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Config registers; only the low byte lane carries data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfgA <= fsa_pkg::RST_CFG_A;
      cfgB <= fsa_pkg::RST_CFG_B;
      mask <= 2'h0;
    end else if (wrEn && wstrb[0]) begin
      if (awaddr == fsa_pkg::ADDR_CFG_A) cfgA <= wdata[7:0];
      if (awaddr == fsa_pkg::ADDR_CFG_B) cfgB <= wdata[7:0];
      if (awaddr == fsa_pkg::ADDR_MASK)  mask <= wdata[1:0];
    end
  end

  // Config C: writing 1 to recalibrate starts it; a 0 during a run is ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfgC <= fsa_pkg::RST_CFG_C;
    end else begin
      if (wrEn && wstrb[0] && awaddr == fsa_pkg::ADDR_CFG_C) begin
        cfgC[6:0] <= wdata[6:0];
        if (wdata[fsa_pkg::CC_OFFSET_RECALIBRATE]) cfgC[fsa_pkg::CC_OFFSET_RECALIBRATE] <= 1'b1;
      end
      if (rcState == fsa_pkg::RC_EXIT) cfgC[fsa_pkg::CC_OFFSET_RECALIBRATE] <= 1'b0;
    end
  end

  // Recalibration sequencer
  always_comb begin
    next_rcState = rcState;
    unique case (rcState)
      fsa_pkg::RC_IDLE:   if (cfgC[fsa_pkg::CC_OFFSET_RECALIBRATE]) next_rcState = fsa_pkg::RC_HOLD;
      fsa_pkg::RC_HOLD:   next_rcState = fsa_pkg::RC_ZERO;
      fsa_pkg::RC_ZERO:   if (rampDone) next_rcState = fsa_pkg::RC_DIVRST;
      fsa_pkg::RC_DIVRST: next_rcState = fsa_pkg::RC_BACK;
      fsa_pkg::RC_BACK:   if (rampDone) next_rcState = fsa_pkg::RC_EXIT;
      fsa_pkg::RC_EXIT:   next_rcState = fsa_pkg::RC_IDLE;
      default:            next_rcState = fsa_pkg::RC_IDLE;
    endcase
  end

  // Sequencer outputs are registered from the next state so they align with it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rcState      <= fsa_pkg::RC_IDLE;
      miniHoldover <= 1'b0;
      rampToZero   <= 1'b0;
      rampToOffset <= 1'b0;
      dividerReset <= 1'b0;
    end else begin
      rcState      <= next_rcState;
      miniHoldover <= !(next_rcState inside {fsa_pkg::RC_IDLE, fsa_pkg::RC_EXIT});
      rampToZero   <= next_rcState == fsa_pkg::RC_ZERO;
      rampToOffset <= next_rcState == fsa_pkg::RC_BACK;
      dividerReset <= next_rcState == fsa_pkg::RC_DIVRST;
    end
  end

  // Frame and multiframe shaping
  assign selAux = cfgA[fsa_pkg::CA_DPLL_SEL] && !auxLocksToMain;
  assign sq8    = selAux ? auxFrame : mainFrame;
  assign sq2    = selAux ? auxMultiframe : mainMultiframe;
  assign rise8  = sq8 && !prev8;
  assign rise2  = sq2 && !prev2;

  // Narrow pulse starts on the square's rising edge, ends at next OC3 tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev8 <= 1'b0;
      prev2 <= 1'b0;
      pul8  <= 1'b0;
      pul2  <= 1'b0;
    end else begin
      prev8 <= sq8;
      prev2 <= sq2;
      pul8  <= rise8 || (pul8 && !oc3Tick);
      pul2  <= rise2 || (pul2 && !oc3Tick);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      framePulseOut      <= 1'b0;
      multiframePulseOut <= 1'b0;
    end else begin
      framePulseOut      <= (cfgA[fsa_pkg::CA_FP_NAR] ? pul8 : sq8) ^ cfgA[fsa_pkg::CA_FP_INV];
      multiframePulseOut <= (cfgA[fsa_pkg::CA_MF_NAR] ? pul2 : sq2) ^ cfgA[fsa_pkg::CA_MF_INV];
    end
  end

  // Sync pin pairing
  assign threePin = cfgC[3:2] == 2'b11;
  always_comb begin
    next_pair1 = fsa_pkg::CLK_NONE;
    next_pair2 = fsa_pkg::CLK_NONE;
    next_pair3 = fsa_pkg::CLK_NONE;
    undefSrc   = 1'b0;
    if (threePin) begin
      // Pairing msb clear is treated like set with both low bits clear
      next_pair1 = (cfgA[fsa_pkg::CA_PAIR_MSB] && cfgA[fsa_pkg::CA_PAIR_LSB]) ? 4'h5 : 4'h3;
      next_pair2 = (cfgA[fsa_pkg::CA_PAIR_MSB] && cfgA[fsa_pkg::CA_PAIR_LSB]) ? 4'h6 : 4'h4;
      next_pair3 = (cfgA[fsa_pkg::CA_PAIR_MSB] && cfgA[fsa_pkg::CA_PAIR_MID]) ? 4'h2 : 4'h9;
    end else begin
      unique case (cfgC[3:0])
        4'h0:    next_pair1 = 4'h1;
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9: next_pair1 = cfgC[3:0];
        default: undefSrc = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pairClk1     <= fsa_pkg::CLK_NONE;
      pairClk2     <= fsa_pkg::CLK_NONE;
      pairClk3     <= fsa_pkg::CLK_NONE;
      threePinMode <= 1'b0;
      syncIgnored  <= 1'b0;
    end else begin
      pairClk1     <= next_pair1;
      pairClk2     <= next_pair2;
      pairClk3     <= next_pair3;
      threePinMode <= threePin;
      syncIgnored  <= undefSrc;
    end
  end

  // Pin synchroniser; only the second stage is read by logic
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncMeta <= 3'h0;
      syncSafe <= 3'h0;
    end else begin
      syncMeta <= syncPin;
      syncSafe <= syncMeta;
    end
  end

  // Sampling rate follows the high-rate bit; ticks arrive at half intervals
  assign halfTick = cfgB[fsa_pkg::CB_HIGHRATE] ? refRateHalfTick : lowRateHalfTick;
  assign tick     = halfTick && halfPhase;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) halfPhase <= 1'b0;
    else if (halfTick) halfPhase <= !halfPhase;
  end

  // Per-pin half-interval history; the phase code picks the tap
  for (genvar p = 0; p < 3; p++) begin : g_pin
    logic [1:0] phCode, tap;
    assign phCode = cfgB[2*p +: 2];
    always_comb begin
      unique case (phCode)
        fsa_pkg::PH_HALF_EARLY: tap = 2'd0;
        fsa_pkg::PH_COINC:      tap = 2'd1;
        fsa_pkg::PH_HALF_LATE:  tap = 2'd2;
        fsa_pkg::PH_ONE_LATE:   tap = 2'd3;
      endcase
    end
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        hist[p]        <= 4'hF;
        sampled[p]     <= 1'b1;
        sampledPrev[p] <= 1'b1;
        syncFall[p]    <= 1'b0;
      end else begin
        if (halfTick) hist[p] <= {hist[p][2:0], syncSafe[p]};
        if (tick) begin
          sampled[p]     <= hist[p][tap];
          sampledPrev[p] <= sampled[p];
        end
        syncFall[p] <= tick && sampledPrev[p] && !sampled[p];
      end
    end
  end

  // Pin 1 only in single mode, all three pins in three-pin mode
  assign syncEvt = !undefSrc && (syncFall[0] || (threePin && (syncFall[1] || syncFall[2])));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resyncAll       <= 1'b0;
      resyncFrameOnly <= 1'b0;
    end else begin
      resyncAll       <= syncEvt && !cfgB[fsa_pkg::CB_DECOUPLE];
      resyncFrameOnly <= syncEvt && cfgB[fsa_pkg::CB_DECOUPLE];
    end
  end

  // Misalignment monitor, counted in sampling ticks around multiframe edges
  assign limit = 4'(cfgC[6:4]) + 4'h1;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sinceMf       <= fsa_pkg::MON_MAX;
      pendCnt       <= 4'h0;
      pending       <= 1'b0;
      misalignAlarm <= 1'b0;
    end else begin
      if (rise2) sinceMf <= 4'h0;
      else if (tick && sinceMf != fsa_pkg::MON_MAX) sinceMf <= sinceMf + 4'h1;
      if (syncEvt) begin
        if (sinceMf <= limit) begin
          misalignAlarm <= 1'b0;
          pending       <= 1'b0;
        end else begin
          pending <= 1'b1;
          pendCnt <= limit;
        end
      end else if (pending) begin
        if (rise2) begin
          pending       <= 1'b0;
          misalignAlarm <= 1'b0;
        end else if (tick) begin
          if (pendCnt == 4'h1) begin
            pending       <= 1'b0;
            misalignAlarm <= 1'b1;
          end
          pendCnt <= pendCnt - 4'h1;
        end
      end
    end
  end

  // Sticky status, cleared by a read; a new event in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= 2'h0;
      irq    <= 1'b0;
    end else begin
      if (rdEn && araddr == fsa_pkg::ADDR_STATUS) status <= 2'h0;
      if (pending && tick && pendCnt == 4'h1 && !rise2 && !syncEvt) status[fsa_pkg::ST_MISALIGN] <= 1'b1;
      if (rcState == fsa_pkg::RC_EXIT) status[fsa_pkg::ST_OFFSET_RECALIBRATE] <= 1'b1;
      irq <= |(status & mask);
    end
  end

  sequence s_offset_recalibrate_enter;
    $rose(miniHoldover);
  endsequence
  sequence s_ramp_zero;
    rampToZero && miniHoldover;
  endsequence

  a_offset_recalibrate_order: assert property (s_offset_recalibrate_enter |=> s_ramp_zero)
    else $error("ramp to zero did not follow holdover entry");
  a_div_pulse: assert property (dividerReset |=> !dividerReset && rampToOffset && miniHoldover)
    else $error("divider reset not followed by ramp back");
  a_offset_recalibrate_clear: assert property (rcState == fsa_pkg::RC_EXIT |=> !cfgC[fsa_pkg::CC_OFFSET_RECALIBRATE] && !miniHoldover)
    else $error("recalibrate bit not cleared at completion");
  a_main_forced: assert property (auxLocksToMain && !cfgA[fsa_pkg::CA_FP_NAR] && !cfgA[fsa_pkg::CA_FP_INV]
                                  |=> framePulseOut == $past(mainFrame))
    else $error("frame output not taken from main dpll");
  a_fp_invert: assert property (!cfgA[fsa_pkg::CA_FP_NAR] && cfgA[fsa_pkg::CA_FP_INV]
                                |=> framePulseOut != $past(sq8))
    else $error("frame output not inverted");
  a_fp_narrow: assert property (cfgA[fsa_pkg::CA_FP_NAR] && !cfgA[fsa_pkg::CA_FP_INV] && pul8 && oc3Tick && !rise8
                                |=> ##1 !framePulseOut)
    else $error("frame pulse wider than one oc3 period");
  a_mf_invert: assert property (!cfgA[fsa_pkg::CA_MF_NAR] && cfgA[fsa_pkg::CA_MF_INV]
                                |=> multiframePulseOut != $past(sq2))
    else $error("multiframe output not inverted");
  a_mf_narrow: assert property (cfgA[fsa_pkg::CA_MF_NAR] && rise2 |=> pul2)
    else $error("multiframe pulse not started on edge");
  a_resync_split: assert property (resyncFrameOnly |-> !resyncAll && $past(cfgB[fsa_pkg::CB_DECOUPLE]))
    else $error("frame-only resync with decouple clear");
  a_pair_three: assert property ($past(threePin && cfgA[fsa_pkg::CA_PAIR_MSB] && cfgA[fsa_pkg::CA_PAIR_LSB]
                                       && !cfgA[fsa_pkg::CA_PAIR_MID])
                                 |-> pairClk1 == 4'h5 && pairClk2 == 4'h6 && pairClk3 == 4'h9)
    else $error("three-pin pairing wrong");
  a_pair_single: assert property ($past(cfgC[3:0] == 4'h0) |-> pairClk1 == 4'h1 && !threePinMode)
    else $error("source code 0 not paired with clock 1");
  a_undef_quiet: assert property (syncIgnored |-> !resyncAll && !resyncFrameOnly && pairClk1 == 4'h0)
    else $error("undefined source did not ignore sync");
  a_alarm_cause: assert property ($rose(misalignAlarm) |-> $past(pending && tick))
    else $error("alarm raised without an expired window");
endmodule : fsa_frame_sync

/* test/fsa_timing_card.sv */
/*
 Timing-card model: DPLL frame squares, output_clock_3 tick, sampling
 half ticks, phase ramp completion and the three external sync pins.
 Assumes one ref_clk domain and a bench that steers sync offset.
*/
`timescale 1ns/1ps
module fsa_timing_card (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       syncEn,
  input  wire logic [6:0] syncOff,
  input  wire logic       rampToZero,
  input  wire logic       rampToOffset,
  output logic            mainFrame,
  output logic            auxFrame,
  output logic            mainMultiframe,
  output logic            auxMultiframe,
  output logic            oc3Tick,
  output logic            lowRateHalfTick,
  output logic            refRateHalfTick,
  output logic            rampDone,
  output logic [2:0]      syncPin
);
  logic [6:0] phaseCnt;
  logic [3:0] rampCnt;
  logic [6:0] sinceFall;

  // One multiframe is 128 cycles, four frames of 32
  always_ff @(posedge ref_clk) begin
    if (!rst_n) phaseCnt <= 7'h00;
    else phaseCnt <= phaseCnt + 7'h01;
  end

  // Aux squares run in antiphase so a wrong DPLL choice shows at once
  assign mainFrame       = ~phaseCnt[4];
  assign auxFrame        = phaseCnt[4];
  assign mainMultiframe  = ~phaseCnt[6];
  assign auxMultiframe   = phaseCnt[6];
  assign oc3Tick         = (phaseCnt[1:0] == 2'h0);
  assign lowRateHalfTick = (phaseCnt[1:0] == 2'h0);
  assign refRateHalfTick = phaseCnt[0];

  // Sync falls on a tick boundary, offset from the multiframe edge; idles high
  assign sinceFall = phaseCnt - syncOff;
  assign syncPin   = {3{~(syncEn && sinceFall < 7'h10)}};

  // Each ramp takes ten cycles; a slow ramp is the realistic case
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !(rampToZero || rampToOffset)) rampCnt <= 4'h0;
    else rampCnt <= rampCnt + 4'h1;
  end
  assign rampDone = (rampCnt == 4'hA);
endmodule : fsa_timing_card

/* test/frame_sync_alignment_config_tb.sv */
/*
 Self-checking bench for the frame-sync block over AXI4-Lite.
 Assumes fsa_pkg and the timing-card model are compiled first.
*/
`timescale 1ns/1ps
module frame_sync_alignment_config_tb;
  logic        ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, auxLocksToMain, syncEn;
  logic        awready, wready, bvalid, arready, rvalid, mainFrame, auxFrame, mainMultiframe;
  logic        auxMultiframe, oc3Tick, lowRateHalfTick, refRateHalfTick, rampDone, framePulseOut;
  logic        multiframePulseOut, threePinMode, syncIgnored, resyncAll, resyncFrameOnly;
  logic        miniHoldover, rampToZero, rampToOffset, dividerReset, misalignAlarm, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, pairClk1, pairClk2, pairClk3;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  syncPin;
  logic [6:0]  syncOff;
  int          fail_count, checks, cyc;

  fsa_frame_sync i_fsa_frame_sync (.ref_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .mainFrame, .auxFrame, .mainMultiframe, .auxMultiframe, .auxLocksToMain, .oc3Tick,
    .syncPin, .lowRateHalfTick, .refRateHalfTick, .rampDone, .framePulseOut, .multiframePulseOut,
    .pairClk1, .pairClk2, .pairClk3, .threePinMode, .syncIgnored, .resyncAll, .resyncFrameOnly,
    .miniHoldover, .rampToZero, .rampToOffset, .dividerReset, .misalignAlarm, .irq);
  fsa_timing_card i_fsa_timing_card (.ref_clk, .rst_n, .syncEn, .syncOff, .rampToZero, .rampToOffset,
    .mainFrame, .auxFrame, .mainMultiframe, .auxMultiframe, .oc3Tick, .lowRateHalfTick,
    .refRateHalfTick, .rampDone, .syncPin);

  // Free-running 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Hang guard well above the expected few thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Write address and data offered together; each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    awaddr <= a; wdata <= {24'h000000, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp; bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  task automatic t_reset();
    chk(pairClk1, 32'h0);
    chk(syncIgnored, 32'h1);
    rd(fsa_pkg::ADDR_CFG_A); chk(d, 32'h00);
    rd(fsa_pkg::ADDR_CFG_B); chk(d, 32'h00);
    rd(fsa_pkg::ADDR_CFG_C); chk(d, 32'h2B);
    rd(12'h100); chk(r, fsa_pkg::RESP_SLVERR); chk(d, 32'h0);
    wr(12'h100, 8'h5A);
    chk(r, fsa_pkg::RESP_SLVERR);
  endtask : t_reset

  // Every single-pin source code, undefined ones included
  task automatic t_source();
    int e;
    for (int i = 0; i < 12; i++) begin
      e = (i == 0) ? 1 : (i == 1 || i == 7 || i > 9) ? 0 : i;
      wr(fsa_pkg::ADDR_CFG_C, 8'(i)); repeat (3) @(posedge ref_clk);
      chk(pairClk1, e);
      chk(syncIgnored, e == 0);
      chk(threePinMode, 32'h0);
      chk(r, fsa_pkg::RESP_OKAY);
    end
  endtask : t_source

  task automatic t_three();
    wr(fsa_pkg::ADDR_CFG_C, 8'h0C);
    for (int i = 4; i < 8; i++) begin
      wr(fsa_pkg::ADDR_CFG_A, 8'(i << 4)); repeat (3) @(posedge ref_clk);
      chk(threePinMode, 32'h1);
      chk(pairClk1, i[0] ? 5 : 3);
      chk(pairClk2, i[0] ? 6 : 4);
      chk(pairClk3, i[1] ? 2 : 9);
    end
  endtask : t_three

  // Square outputs follow the chosen DPLL one cycle late; edges skipped
  task automatic t_shape(input logic [7:0] c, input logic lk);
    logic ef, em, pf, pm;
    wr(fsa_pkg::ADDR_CFG_A, c); auxLocksToMain <= lk; repeat (3) @(posedge ref_clk);
    pf = 1'bx; pm = 1'bx;
    repeat (64) begin
      @(posedge ref_clk);
      ef = ((c[7] && !lk) ? auxFrame : mainFrame) ^ c[3];
      em = ((c[7] && !lk) ? auxMultiframe : mainMultiframe) ^ c[1];
      if (ef === pf) chk(framePulseOut, ef);
      if (em === pm) chk(multiframePulseOut, em);
      pf = ef; pm = em;
    end
  endtask : t_shape

  task automatic t_narrow();
    int fr, mr, fh, mh;
    logic pf, pm;
    fr = 0; mr = 0; fh = 0; mh = 0;
    wr(fsa_pkg::ADDR_CFG_A, 8'h05); repeat (4) @(posedge ref_clk);
    pf = framePulseOut; pm = multiframePulseOut;
    repeat (128) begin
      @(posedge ref_clk);
      fr += (!pf && framePulseOut); mr += (!pm && multiframePulseOut);
      fh += framePulseOut; mh += multiframePulseOut;
      pf = framePulseOut; pm = multiframePulseOut;
    end
    chk(fr, 4);
    chk(mr, 1);
    chk(fh >= 4 && fh <= 20, 1);
    chk(mh >= 1 && mh <= 5, 1);
  endtask : t_narrow

  task automatic t_resync(input logic [7:0] b, input int ea, input int ef);
    int na, nf;
    na = 0; nf = 0;
    wr(fsa_pkg::ADDR_CFG_B, b); repeat (10) @(posedge ref_clk);
    repeat (256) begin
      @(posedge ref_clk);
      na += resyncAll; nf += resyncFrameOnly;
    end
    chk(na, ea);
    chk(nf, ef);
    chk(misalignAlarm, 32'h0);
  endtask : t_resync

  // One sampling interval is 4 cycles at the high rate; codes 0 and 2, and 1 and 3, put the resync pulse that far apart
  task automatic t_phase();
    int   lat [4];
    int   n;
    logic pm;
    for (int c = 0; c < 4; c++) begin
      wr(fsa_pkg::ADDR_CFG_B, 8'(32'h40 | c));
      repeat (10) @(posedge ref_clk);
      n = -1;
      pm = 1'b1;
      lat[c] = 0;
      repeat (160) begin
        @(posedge ref_clk);
        if (mainMultiframe && !pm) n = 0;
        else if (n >= 0) n++;
        if (resyncAll && n > 0 && lat[c] == 0) lat[c] = n;
        pm = mainMultiframe;
      end
    end
    chk(lat[2] - lat[0], 32'h4);
    chk(lat[3] - lat[1], 32'h4);
    chk(lat[0] > 0 && lat[1] <= lat[0] && lat[3] >= lat[0], 32'h1);
  endtask : t_phase

  // A 40-cycle offset is 5 low-rate ticks but 10 high-rate ones
  task automatic t_monitor();
    wr(fsa_pkg::ADDR_MASK, 8'h00);
    syncOff <= 7'h28; wr(fsa_pkg::ADDR_CFG_B, 8'h00); repeat (300) @(posedge ref_clk);
    chk(misalignAlarm, 32'h0);
    wr(fsa_pkg::ADDR_CFG_B, 8'h40); repeat (300) @(posedge ref_clk);
    chk(misalignAlarm, 32'h1);
    rd(fsa_pkg::ADDR_STATE);
    chk(d[0], 32'h1);
    chk(irq, 32'h0);
    rd(fsa_pkg::ADDR_STATUS); chk(d[0], 32'h1);
    syncEn <= 1'b0;
  endtask : t_monitor

  task automatic t_offset_recalibrate();
    int st, nd;
    st = 0; nd = 0;
    wr(fsa_pkg::ADDR_MASK, 8'h02); rd(fsa_pkg::ADDR_STATUS);
    wr(fsa_pkg::ADDR_CFG_C, 8'hF0);
    repeat (200) begin
      @(posedge ref_clk);
      if (rampToZero || rampToOffset || dividerReset) chk(miniHoldover, 32'h1);
      if (rampToZero && st == 0) st = 1;
      if (dividerReset) nd++;
      if (dividerReset && st == 1) st = 2;
      if (rampToOffset && st == 2) st = 3;
    end
    chk(st, 3);
    chk(nd, 1);
    chk(miniHoldover, 32'h0);
    rd(fsa_pkg::ADDR_CFG_C); chk(d, 32'h70);
    chk(irq, 32'h1);
    rd(fsa_pkg::ADDR_STATUS); chk(d[1], 32'h1);
    repeat (3) @(posedge ref_clk);
    chk(irq, 32'h0);
  endtask : t_offset_recalibrate

  // Main sequence
  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hF; auxLocksToMain = 1'b0;
    syncEn = 1'b0; syncOff = 7'h00; fail_count = 0; checks = 0; cyc = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_source();
    t_three();
    t_shape(8'h00, 1'b0);
    t_shape(8'h0A, 1'b0);
    t_shape(8'h80, 1'b0);
    t_shape(8'h8A, 1'b1);
    t_narrow();
    syncEn <= 1'b1; wr(fsa_pkg::ADDR_CFG_C, 8'h70);
    t_resync(8'h40, 2, 0);
    t_resync(8'hC0, 0, 2);
    t_phase();
    t_monitor();
    t_offset_recalibrate();
    end_of_test();
  end
endmodule : frame_sync_alignment_config_tb
